/* design/lsio_map.svh */
`ifndef LSIO_MAP_SVH
`define LSIO_MAP_SVH

// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define LSIO_DATA_LANES      16
`define LSIO_FUNC_LINES      4
`define LSIO_SE_FUNC_LINES   4
`define LSIO_WORD_W          16
`define LSIO_CHAN_RATIO      10
`define LSIO_GRP_RATIO       6
`define LSIO_GRP_FUNC_W      8
`define LSIO_CNT_W           4
// Clock index inside the clock-output group
`define LSIO_CLK_LVDS        0
`define LSIO_CLK_SE          1
`define LSIO_CLK_OUTS        2
// Variant codes
`define LSIO_VAR_PLAIN       2'h0
`define LSIO_VAR_CHAN        2'h1
`define LSIO_VAR_GRP         2'h2

`endif

/* design/lsio_pkg.sv */
package lsio_pkg;
	typedef enum logic [1:0] {
		LSIO_PLAIN = 2'h0,
		LSIO_CHAN  = 2'h1,
		LSIO_GRP   = 2'h2
	} lsio_variant_t;
endpackage

/* design/lsio_ser.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lsio_map.svh"

// ----------------------------------------------------------------------
// Output serialiser: loads a parallel word and shifts it out two bits
// per core clock (one per fast-clock edge), lsb first.
// ----------------------------------------------------------------------
module lsio_ser (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	// Parallel side
	input  wire logic [`LSIO_CNT_W-1:0]   ratio,
	input  wire logic                     load,
	input  wire logic [`LSIO_CHAN_RATIO-1:0] word,
	// Serial side: bit for rising edge, bit for falling edge
	output logic      [1:0]               ddr_bits
);
	logic [`LSIO_CHAN_RATIO-1:0] shreg;

	// Shift register; lsb leaves first
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			shreg <= '0;
		end else if (load) begin
			shreg <= word;
		end else begin
			shreg <= {2'h0, shreg[`LSIO_CHAN_RATIO-1:2]};
		end
	end

	// Registered DDR pair
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ddr_bits <= 2'h0;
		end else begin
			ddr_bits <= load ? word[1:0] : shreg[3:2];
		end
	end
endmodule
`default_nettype wire

/* design/lsio_des.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lsio_map.svh"

// ----------------------------------------------------------------------
// Input deserialiser: gathers two bits per core clock, lsb first,
// and presents the word on the cycle after the last pair arrives.
// ----------------------------------------------------------------------
module lsio_des (
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rstn,
	// Serial side
	input  wire logic [1:0]                  ddr_bits,
	input  wire logic                        last,
	// Parallel side
	output logic      [`LSIO_CHAN_RATIO-1:0] word
);
	logic [`LSIO_CHAN_RATIO-1:0] acc;
	logic [`LSIO_CHAN_RATIO-1:0] next_acc;

	// New pair enters at the top, earlier bits slide to the lsb
	assign next_acc = {ddr_bits, acc[`LSIO_CHAN_RATIO-1:2]};

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			acc <= '0;
		end else begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			word <= '0;
		end else if (last) begin
			word <= next_acc;
		end
	end
endmodule
`default_nettype wire

/* design/lsio_adapter.sv */
// Operation
// [R1] All variants carry the same connector lines
// [R2] Each clock output inverts on its own
// [R3] Plain: data and direction as 16-bit words
// [R4] Plain: each function line a single bit
// [R5] Channel: 16-bit word per channel, top six ignored
// [R6] Serdes variants: every line through serialiser/deserialiser; single-ended function lines stay plain bits here
// [R7] Channel variant ratio defaults to ten
// [R8] Channel variant moves ten bits per word
// [R9] Serdes run DDR, one bit per edge; here one bit of each pair per core clock, picked by ddr_phase
// [R10] Grouped variant ratio defaults to six
// [R11] Grouped moves six samples per regional cycle
// [R12] Grouped: data and direction as 16-bit words
// [R13] Grouped: function lines in 8-bit word
// [R14] Channel variant per-channel ports, others bundled
// [R15] Output enable low drives, high releases line
// [R16] First serialised bit is word lsb
// [R17] Input-direction channels ignore written output value
`timescale 1ns/100ps
`default_nettype none
`include "lsio_map.svh"

module lsio_adapter
	import lsio_pkg::*;
#(
	parameter lsio_variant_t VARIANT = LSIO_PLAIN
) (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rstn,
	// Clock output inversion
	input  wire logic [`LSIO_CLK_OUTS-1:0]     clk_invert,
	// Plain and grouped user side (bundled per connector)
	input  wire logic [`LSIO_WORD_W-1:0]       user_data_out,
	input  wire logic [`LSIO_WORD_W-1:0]       user_data_dir,
	output logic      [`LSIO_WORD_W-1:0]       user_data_in,
	input  wire logic [`LSIO_GRP_FUNC_W-1:0]   user_func_out,
	input  wire logic [`LSIO_GRP_FUNC_W-1:0]   user_func_dir,
	output logic      [`LSIO_GRP_FUNC_W-1:0]   user_func_in,
	input  wire logic [`LSIO_SE_FUNC_LINES-1:0] user_se_out,
	input  wire logic [`LSIO_SE_FUNC_LINES-1:0] user_se_dir,
	output logic      [`LSIO_SE_FUNC_LINES-1:0] user_se_in,
	output logic                               user_strobe,
	output logic                               user_clk_in,
	// Per-channel user side (channel variant)
	input  wire logic [`LSIO_WORD_W-1:0]       chan_out [`LSIO_DATA_LANES],
	output logic      [`LSIO_WORD_W-1:0]       chan_in  [`LSIO_DATA_LANES],
	input  wire logic [`LSIO_WORD_W-1:0]       fchan_out [`LSIO_FUNC_LINES],
	output logic      [`LSIO_WORD_W-1:0]       fchan_in  [`LSIO_FUNC_LINES],
	output logic                               word_tick,
	// Connector: data lanes (output enable low while driving)
	input  wire logic [`LSIO_DATA_LANES-1:0]   data_lane_i,
	output logic      [`LSIO_DATA_LANES-1:0]   data_lane_o,
	output logic      [`LSIO_DATA_LANES-1:0]   data_lane_oe_n,
	// Connector: LVDS function lines
	input  wire logic [`LSIO_FUNC_LINES-1:0]   function_line_i,
	output logic      [`LSIO_FUNC_LINES-1:0]   function_line_o,
	output logic      [`LSIO_FUNC_LINES-1:0]   function_line_oe_n,
	// Connector: single-ended function lines
	input  wire logic [`LSIO_SE_FUNC_LINES-1:0] single_ended_function_line_i,
	output logic      [`LSIO_SE_FUNC_LINES-1:0] single_ended_function_line_o,
	output logic      [`LSIO_SE_FUNC_LINES-1:0] single_ended_function_line_oe_n,
	// Connector: strobe in, clock in, LVDS clock out
	input  wire logic                          strobe_pin,
	input  wire logic                          clk_in_pin,
	output logic                               lvds_clk_out
);
	// ------------------------------------------------------------------
	// Variant constants
	// ------------------------------------------------------------------
	localparam logic SERDES = (VARIANT != LSIO_PLAIN);
	localparam logic [`LSIO_CNT_W-1:0] RATIO = (VARIANT == LSIO_GRP) ?
		`LSIO_CNT_W'(`LSIO_GRP_RATIO) :
		`LSIO_CNT_W'(`LSIO_CHAN_RATIO);                   // see [R7] [R10]
	localparam int NPAIR = int'(RATIO) / 2;

	// Pair index of the word slot; wraps at RATIO/2 core clocks
	function automatic logic is_last(input logic [`LSIO_CNT_W-1:0] c);
		is_last = (c == `LSIO_CNT_W'(NPAIR - 1));
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisers: every pin passes two flops first
	// ------------------------------------------------------------------
	logic [`LSIO_DATA_LANES-1:0]    dl_s1, dl_s2;
	logic [`LSIO_FUNC_LINES-1:0]    fl_s1, fl_s2;
	logic [`LSIO_SE_FUNC_LINES-1:0] se_s1, se_s2;
	logic [1:0]                     ck_s1, ck_s2;

	// Two-stage sync; first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			dl_s1 <= '0;
			dl_s2 <= '0;
			fl_s1 <= '0;
			fl_s2 <= '0;
			se_s1 <= '0;
			se_s2 <= '0;
			ck_s1 <= 2'h0;
			ck_s2 <= 2'h0;
		end else begin
			dl_s1 <= data_lane_i;
			dl_s2 <= dl_s1;
			fl_s1 <= function_line_i;
			fl_s2 <= fl_s1;
			se_s1 <= single_ended_function_line_i;
			se_s2 <= se_s1;
			ck_s1 <= {clk_in_pin, strobe_pin};
			ck_s2 <= ck_s1;
		end
	end

	// ------------------------------------------------------------------
	// Word slot counter (regional clock stand-in for serdes variants)
	// ------------------------------------------------------------------
	logic [`LSIO_CNT_W-1:0] pair_cnt;
	logic                   last;
	assign last = is_last(pair_cnt);

	// One word per RATIO/2 core clocks, two bits per clock
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pair_cnt <= '0;
		end else if (last) begin
			pair_cnt <= '0;                                   // see [R11]
		end else begin
			pair_cnt <= pair_cnt + `LSIO_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			word_tick <= 1'b0;
		end else begin
			word_tick <= SERDES && last;
		end
	end

	// ------------------------------------------------------------------
	// Per-line parallel words for the serdes variants
	// ------------------------------------------------------------------
	localparam int NLINE = `LSIO_DATA_LANES + `LSIO_FUNC_LINES + 1;
	logic [`LSIO_CHAN_RATIO-1:0] tx_word [NLINE];
	logic [`LSIO_CHAN_RATIO-1:0] rx_word [NLINE];
	logic [1:0]                  tx_pair [NLINE];
	logic [1:0]                  rx_pair [NLINE];
	logic [`LSIO_CHAN_RATIO-1:0] clk_pattern;

	// Clock pattern: rising half then falling half of each word
	always_comb begin
		clk_pattern = '0;
		for (int b = 0; b < `LSIO_CHAN_RATIO; b++) begin
			if (b < int'(RATIO) / 2) begin
				clk_pattern[b] = 1'b1;
			end
		end
	end

	// Build outgoing words; grouped repeats bit i of the one user word in every slot
	always_comb begin
		for (int i = 0; i < NLINE; i++) begin
			tx_word[i] = '0;
		end
		for (int i = 0; i < `LSIO_DATA_LANES; i++) begin
			if (VARIANT == LSIO_CHAN) begin
				tx_word[i] = chan_out[i][`LSIO_CHAN_RATIO-1:0]; // see [R5] [R8]
			end else begin
				tx_word[i] = {`LSIO_CHAN_RATIO{user_data_out[i]}}; // see [R12]
			end
		end
		for (int i = 0; i < `LSIO_FUNC_LINES; i++) begin
			if (VARIANT == LSIO_CHAN) begin
				tx_word[`LSIO_DATA_LANES + i] =
					fchan_out[i][`LSIO_CHAN_RATIO-1:0];
			end else begin
				tx_word[`LSIO_DATA_LANES + i] =
					{`LSIO_CHAN_RATIO{user_func_out[i]}};           // see [R13]
			end
		end
		// Clock word, inverted on request
		tx_word[NLINE-1] = clk_invert[`LSIO_CLK_LVDS] ?
			~clk_pattern : clk_pattern;                       // see [R2]
	end

	// One serialiser and one deserialiser per line
	for (genvar g = 0; g < NLINE; g++) begin : g_line
		lsio_ser u_ser (
			.core_clk (core_clk),
			.rstn     (rstn),
			.ratio    (RATIO),
			.load     (last),
			.word     (tx_word[g]),
			.ddr_bits (tx_pair[g])                            // see [R6] [R16]
		);
		lsio_des u_des (
			.core_clk (core_clk),
			.rstn     (rstn),
			.ddr_bits (rx_pair[g]),
			.last     (last),
			.word     (rx_word[g])
		);
	end

	// Receive pairs: one synchronised sample per core clock fills both halves
	always_comb begin
		for (int i = 0; i < `LSIO_DATA_LANES; i++) begin
			rx_pair[i] = {2{dl_s2[i]}};                       // see [R9]
		end
		for (int i = 0; i < `LSIO_FUNC_LINES; i++) begin
			rx_pair[`LSIO_DATA_LANES + i] = {2{fl_s2[i]}};
		end
		rx_pair[NLINE-1] = {2{ck_s2[0]}};
	end

	// ------------------------------------------------------------------
	// Connector drive; enable low means driving
	// ------------------------------------------------------------------
	logic ddr_phase;

	// DDR phase toggles each clock to pick the DDR bit
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ddr_phase <= 1'b0;
		end else begin
			ddr_phase <= ~ddr_phase;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			data_lane_o     <= '0;
			data_lane_oe_n  <= '1;                            // see [R15]
			function_line_o <= '0;
			function_line_oe_n <= '1;
		end else begin
			for (int i = 0; i < `LSIO_DATA_LANES; i++) begin
				data_lane_oe_n[i] <= ~user_data_dir[i];        // see [R15]
				// Output value is held low while released
				data_lane_o[i] <= user_data_dir[i] & (SERDES ?
					tx_pair[i][ddr_phase] : user_data_out[i]);  // see [R3] [R17]
			end
			for (int i = 0; i < `LSIO_FUNC_LINES; i++) begin
				function_line_oe_n[i] <= ~user_func_dir[i];
				function_line_o[i] <= user_func_dir[i] & (SERDES ?
					tx_pair[`LSIO_DATA_LANES + i][ddr_phase] :
					user_func_out[i]);                          // see [R4]
			end
		end
	end

	// Single-ended lines are always plain bits, in every variant
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			single_ended_function_line_o    <= '0;
			single_ended_function_line_oe_n <= '1;
		end else begin
			single_ended_function_line_oe_n <= ~user_se_dir;
			single_ended_function_line_o    <= user_se_dir & user_se_out; // see [R17]
		end
	end

	// Clock output: clock serialiser bit picked by the DDR phase, high half of each window
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			lvds_clk_out <= 1'b0;
		end else begin
			lvds_clk_out <= tx_pair[NLINE-1][ddr_phase];       // see [R2] [R1]
		end
	end

	// ------------------------------------------------------------------
	// User-side readback
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			user_data_in <= '0;
			user_func_in <= '0;
			user_se_in   <= '0;
			user_strobe  <= 1'b0;
			user_clk_in  <= 1'b0;
			for (int i = 0; i < `LSIO_DATA_LANES; i++) chan_in[i] <= '0;
			for (int i = 0; i < `LSIO_FUNC_LINES; i++) fchan_in[i] <= '0;
		end else begin
			user_se_in  <= se_s2;
			user_strobe <= ck_s2[0];
			// Second clock output index inverts the sensed clock
			user_clk_in <= ck_s2[1] ^ clk_invert[`LSIO_CLK_SE];
			for (int i = 0; i < `LSIO_DATA_LANES; i++) begin
				user_data_in[i] <= SERDES ? rx_word[i][0] : dl_s2[i];
				chan_in[i] <= {6'h00, rx_word[i]};             // see [R5] [R14]
			end
			for (int i = 0; i < `LSIO_FUNC_LINES; i++) begin
				user_func_in[i] <= SERDES ?
					rx_word[`LSIO_DATA_LANES + i][0] : fl_s2[i];
				fchan_in[i] <= {6'h00, rx_word[`LSIO_DATA_LANES + i]};
			end
			user_func_in[`LSIO_GRP_FUNC_W-1:`LSIO_FUNC_LINES] <= 4'h0; // see [R13]
		end
	end
endmodule
`default_nettype wire

/* test/lsio_adapter_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Port checker, plain variant timing
// ----------------------------------------------------------------------
module lsio_adapter_monitor
	import lsio_pkg::*;
#(
	parameter lsio_variant_t VARIANT = LSIO_PLAIN
) (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// User side
	input wire logic [15:0] user_data_out,
	input wire logic [15:0] user_data_dir,
	input wire logic [15:0] user_data_in,
	input wire logic [7:0]  user_func_out,
	input wire logic [7:0]  user_func_dir,
	input wire logic [7:0]  user_func_in,
	input wire logic [3:0]  user_se_out,
	input wire logic [3:0]  user_se_dir,
	input wire logic        word_tick,
	// Connector side
	input wire logic [15:0] data_lane_i,
	input wire logic [15:0] data_lane_o,
	input wire logic [15:0] data_lane_oe_n,
	input wire logic [3:0]  function_line_o,
	input wire logic [3:0]  function_line_oe_n,
	input wire logic [3:0]  single_ended_function_line_o,
	input wire logic [3:0]  single_ended_function_line_oe_n
);
	// Serdes variants move whole words, so bit latencies hold only here
	localparam bit PLAIN = (VARIANT == LSIO_PLAIN);

	chk_reset_idle: assert property (@(posedge core_clk)
		!rstn |=> data_lane_o == 16'h0000 && &data_lane_oe_n
		&& &function_line_oe_n && &single_ended_function_line_oe_n)
		else $error("pins not released after reset");
	chk_lane_enable: assert property (
		@(posedge core_clk) disable iff (!rstn)
		PLAIN && $past(rstn) |-> data_lane_oe_n == ~$past(user_data_dir))
		else $error("lane enable does not follow direction");
	chk_lane_value: assert property (
		@(posedge core_clk) disable iff (!rstn) PLAIN && $past(rstn)
		|-> data_lane_o == ($past(user_data_out) & $past(user_data_dir)))
		else $error("lane value not masked by direction");
	chk_func_enable: assert property (
		@(posedge core_clk) disable iff (!rstn) PLAIN && $past(rstn)
		|-> function_line_oe_n == ~$past(user_func_dir[3:0]))
		else $error("function line enable wrong");
	chk_func_value: assert property (
		@(posedge core_clk) disable iff (!rstn) PLAIN && $past(rstn)
		|-> function_line_o == ($past(user_func_out[3:0])
		& $past(user_func_dir[3:0])))
		else $error("function line value wrong");
	chk_se_drive: assert property (
		@(posedge core_clk) disable iff (!rstn) PLAIN && $past(rstn)
		|-> single_ended_function_line_oe_n == ~$past(user_se_dir)
		&& single_ended_function_line_o == ($past(user_se_out)
		& $past(user_se_dir)))
		else $error("single ended line drive wrong");
	chk_lane_input: assert property (
		@(posedge core_clk) disable iff (!rstn)
		PLAIN && $past(rstn) && $past(rstn, 2) && $past(rstn, 3)
		|-> user_data_in == $past(data_lane_i, 3))
		else $error("lane input latency wrong");
	chk_func_upper: assert property (
		@(posedge core_clk) disable iff (!rstn)
		user_func_in[7:4] == 4'h0)
		else $error("unused function bits not zero");
	chk_no_tick: assert property (
		@(posedge core_clk) disable iff (!rstn) PLAIN |-> !word_tick)
		else $error("word tick in plain variant");
endmodule

bind lsio_adapter lsio_adapter_monitor #(.VARIANT(VARIANT)) i_mon (
	.core_clk, .rstn, .user_data_out, .user_data_dir, .user_data_in,
	.user_func_out, .user_func_dir, .user_func_in, .user_se_out,
	.user_se_dir, .word_tick, .data_lane_i, .data_lane_o, .data_lane_oe_n,
	.function_line_o, .function_line_oe_n, .single_ended_function_line_o,
	.single_ended_function_line_oe_n
);

`default_nettype wire

/* test/lsio_far_end.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Far end: device under test on the connector
// ----------------------------------------------------------------------
module lsio_far_end (
	// Clock control
	input  wire logic        link_run,
	input  wire logic        far_clk_level,
	// Far-side drive values
	input  wire logic [15:0] far_data,
	input  wire logic [3:0]  far_func,
	input  wire logic [3:0]  far_se,
	// Adapter pins
	input  wire logic [15:0] data_lane_o,
	input  wire logic [15:0] data_lane_oe_n,
	input  wire logic [3:0]  function_line_o,
	input  wire logic [3:0]  function_line_oe_n,
	input  wire logic [3:0]  se_o,
	input  wire logic [3:0]  se_oe_n,
	output logic      [15:0] data_lane_i,
	output logic      [3:0]  function_line_i,
	output logic      [3:0]  se_i,
	output logic             clk_in_pin
);
	// Wire level: the far end drives only lines the adapter released
	always_comb begin
		data_lane_i = (data_lane_oe_n & far_data)
			| (~data_lane_oe_n & data_lane_o);
		function_line_i = (function_line_oe_n & far_func)
			| (~function_line_oe_n & function_line_o);
		se_i = (se_oe_n & far_se) | (~se_oe_n & se_o);
	end

	// Clock at 160 ns, parked at a chosen level when stopped
	initial begin
		clk_in_pin = 1'b0;
		forever begin
			#80;
			clk_in_pin = link_run ? ~clk_in_pin : far_clk_level;
		end
	end
endmodule

`default_nettype wire

/* test/tb_lvds_serdes_io_adapter.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Plain variant bench
// ----------------------------------------------------------------------
module tb_lvds_serdes_io_adapter
	import lsio_pkg::*;
;
	logic core_clk, rstn, link_run, far_clk_level, user_strobe, user_clk_in;
	logic word_tick, lvds_clk_out, clk_in_pin, strobe_pin;
	logic [1:0] clk_invert;
	logic [15:0] user_data_out, user_data_dir, user_data_in, far_data;
	logic [15:0] data_lane_i, data_lane_o, data_lane_oe_n;
	logic [7:0] user_func_out, user_func_dir, user_func_in;
	logic [3:0] user_se_out, user_se_dir, user_se_in, far_func, far_se;
	logic [3:0] function_line_i, function_line_o, function_line_oe_n;
	logic [3:0] se_i, se_o, se_oe_n;
	logic [15:0] chan_out [16], chan_in [16], fchan_out [4], fchan_in [4];
	int err_count, checks_done;

	lsio_adapter #(.VARIANT(LSIO_PLAIN)) i_lsio_adapter (
		.core_clk, .rstn, .clk_invert, .user_data_out, .user_data_dir,
		.user_data_in, .user_func_out, .user_func_dir, .user_func_in,
		.user_se_out, .user_se_dir, .user_se_in, .user_strobe, .user_clk_in,
		.chan_out, .chan_in, .fchan_out, .fchan_in, .word_tick,
		.data_lane_i, .data_lane_o, .data_lane_oe_n, .function_line_i,
		.function_line_o, .function_line_oe_n,
		.single_ended_function_line_i(se_i),
		.single_ended_function_line_o(se_o),
		.single_ended_function_line_oe_n(se_oe_n),
		.strobe_pin, .clk_in_pin, .lvds_clk_out);

	lsio_far_end i_lsio_far_end (
		.link_run, .far_clk_level, .far_data, .far_func, .far_se,
		.data_lane_o, .data_lane_oe_n, .function_line_o,
		.function_line_oe_n, .se_o, .se_oe_n, .data_lane_i,
		.function_line_i, .se_i, .clk_in_pin);

	// Core clock, 10 ns
	always #5 core_clk = ~core_clk;

	task automatic check(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Drive patterns: all-in, all-out and mixed, out value opposite of dir in the F0F0 nibbles, equal elsewhere
	task automatic t_drive;
		logic [15:0] pats [4] = '{16'h0000, 16'hFFFF, 16'hA5C3, 16'h0001};
		foreach (pats[k]) begin
			@(posedge core_clk);
			user_data_dir <= pats[k];
			user_data_out <= ~pats[k] ^ 16'h0F0F;
			user_func_dir <= {4'hF, pats[k][3:0]};
			user_func_out <= {4'hF, ~pats[k][7:4]};
			user_se_dir <= pats[k][7:4];
			user_se_out <= pats[k][11:8];
			@(posedge core_clk);
			#1;
			check("lane oe_n", data_lane_oe_n, ~pats[k]);
			check("lane o", data_lane_o, ~pats[k] & 16'hF0F0 & pats[k] ^
				(16'h0F0F & pats[k]));
			check("func o", {12'h0, function_line_o},
				{12'h0, ~pats[k][7:4] & pats[k][3:0]});
			check("se oe_n", {12'h0, se_oe_n}, {12'h0, ~pats[k][7:4]});
			check("se o", {12'h0, se_o},
				{12'h0, pats[k][11:8] & pats[k][7:4]});
		end
	endtask

	// Receive and loopback: released lanes show the far end, driven ones us
	task automatic t_receive(input logic [15:0] dir, out, far);
		@(posedge core_clk);
		user_data_dir <= dir;
		user_data_out <= out;
		user_func_dir <= 8'h00;
		user_se_dir <= 4'h0;
		far_data <= far;
		far_func <= far[3:0];
		far_se <= far[7:4];
		strobe_pin <= far[15];
		repeat (6) @(posedge core_clk);
		#1;
		check("data in", user_data_in, (far & ~dir) | (out & dir));
		check("func in", {8'h0, user_func_in}, {12'h0, far[3:0]});
		check("se in", {12'h0, user_se_in}, {12'h0, far[7:4]});
		check("strobe", {15'h0, user_strobe}, {15'h0, far[15]});
		check("tick", {15'h0, word_tick}, 16'h0000);
	endtask

	// Clock out: ten-cycle window, then the same window phase inverted
	task automatic t_clk_out;
		logic [9:0] v0, v1;
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			#1;
			v0[i] = lvds_clk_out;
		end
		@(posedge core_clk);
		clk_invert[0] <= 1'b1;
		// Nine more edges start the capture 20 cycles after the first, two whole windows later
		repeat (9) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			#1;
			v1[i] = lvds_clk_out;
		end
		check("clk duty", 16'($countones(v0)), 16'h0005);
		check("clk out inv", {6'h0, v1}, {6'h0, ~v0});
	endtask

	// Stop the link clock high, then sense it plain and inverted
	task automatic t_clk_invert;
		int n;
		link_run <= 1'b0;
		far_clk_level <= 1'b1;
		// Let the link clock park before judging the sensed level
		repeat (20) @(posedge core_clk);
		for (int inv = 0; inv < 2; inv++) begin
			@(posedge core_clk);
			clk_invert <= {inv[0], 1'b0};
			n = 0;
			#1;
			while (user_clk_in !== ~inv[0] && n < 40) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			check("clk in", {15'h0, user_clk_in}, {15'h0, ~inv[0]});
			if (n == 40) wrap_up();
		end
		link_run <= 1'b1;
	endtask

	// Main sequence
	initial begin
		{core_clk, rstn, clk_invert, far_clk_level, strobe_pin} = '0;
		{user_data_out, user_data_dir, user_func_out, user_func_dir} = '0;
		{user_se_out, user_se_dir, far_data, far_func, far_se} = '0;
		chan_out = '{default: 16'h0000};
		fchan_out = '{default: 16'h0000};
		link_run = 1'b1;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		check("reset oe_n", data_lane_oe_n, 16'hFFFF);
		t_drive();
		t_receive(16'h0000, 16'hFFFF, 16'h5AF0);
		t_receive(16'hFF00, 16'h1234, 16'hABCD);
		t_receive(16'h00FF, 16'hFFFF, 16'h0000);
		t_clk_invert();
		t_receive(16'h8001, 16'h0000, 16'hFFFF);
		t_clk_out();
		wrap_up();
	end
endmodule

`default_nettype wire
